// ==== clk_ctl_pkg.sv ====
// package for the system clock source control block
// assumes a single 10 MHz control clock; oscillator health arrives as synchronous levels
package clk_ctl_pkg;
	localparam logic [0:0] ADDR_SEL_CTL = 1'h0;
	localparam logic [0:0] ADDR_STAT_AUX = 1'h1;
	localparam int POS_IDLE = 7;
	localparam int POS_FREQ = 4;
	localparam int POS_PRIRUN = 3;
	localparam int POS_HSTABLE = 2;
	localparam int POS_MULTRUN = 7;
	localparam int POS_SECRUN = 6;
	localparam int POS_MEDSEL = 4;
	localparam int POS_SECFORCE = 3;
	localparam int POS_DRIVE = 2;
	localparam int POS_MSTABLE = 1;
	localparam int POS_LSTABLE = 0;
	localparam logic [2:0] FREQ_RESET = 3'h3;
	localparam logic [1:0] SEL_RESET = 2'h0;
	localparam logic DRIVE_RESET = 1'h1;
	localparam logic MEDSEL_RESET = 1'h0;
	localparam logic IDLE_RESET = 1'h0;
	localparam logic SECFORCE_RESET = 1'h0;
	localparam logic [10:0] START_UP_COUNT = 11'h400;
	localparam logic [1:0] TRANSITION_CYCLES = 2'h2;
	// primary mode codes: 0000-0111 external, 1000-1001 internal, 1010-1111 external
	localparam logic [3:0] MODE_LP = 4'h0;
	localparam logic [3:0] MODE_XT = 4'h1;
	localparam logic [3:0] MODE_HS_HP = 4'h2;
	localparam logic [3:0] MODE_HS_MP = 4'h3;
	localparam logic [3:0] MODE_EC_HP_OUT = 4'h4;
	localparam logic [3:0] MODE_EC_HP_IO = 4'h5;
	localparam logic [3:0] MODE_RC_OUT = 4'h6;
	localparam logic [3:0] MODE_RC_IO = 4'h7;
	localparam logic [3:0] MODE_INT_IO = 4'h8;
	localparam logic [3:0] MODE_INT_OUT = 4'h9;
	localparam logic [3:0] MODE_EC_MP_OUT = 4'hA;
	localparam logic [3:0] MODE_EC_MP_IO = 4'hB;

	typedef enum logic [1:0] {SRC_PRIMARY, SRC_SECONDARY, SRC_INTERNAL} clk_src_t;
	typedef enum logic [3:0] {
		INT_16M, INT_8M, INT_4M, INT_2M, INT_1M, INT_500K_HF, INT_250K_HF, INT_31K_HF,
		INT_500K_MF, INT_250K_MF, INT_31K_MF, INT_31K_LF
	} int_tap_t;

	typedef struct packed {
		logic [0:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic [3:0] primary_mode_config;
		logic multiplier_config;
		logic multiplier_enable;
		logic low_freq_source_select;
		logic primary_clock_allow;
	} cfg_t;

	typedef struct packed {
		logic primary_ok;
		logic secondary_ok;
		logic high_ok;
		logic medium_ok;
		logic low_ok;
	} osc_health_t;

	function automatic logic is_crystal(input logic [3:0] m);
		return (m == MODE_LP) || (m == MODE_XT) || (m == MODE_HS_HP) || (m == MODE_HS_MP);
	endfunction

	function automatic logic is_internal(input logic [3:0] m);
		return (m == MODE_INT_IO) || (m == MODE_INT_OUT);
	endfunction
endpackage

// ==== start_up_counter.sv ====
// start-up counter: counts primary oscillator cycles before releasing execution
// assumes osc_tick is a one-cycle pulse per primary oscillator cycle, synchronous to clk
module start_up_counter
	import clk_ctl_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic restart,
	input wire logic bypass,
	input wire logic osc_tick,
	output logic done
);
	typedef struct packed {
		logic [10:0] cnt;
		logic done;
	} cnt_state_t;
	cnt_state_t s_r, s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (restart) begin
			s_nxt.cnt = 11'h000;
			s_nxt.done = bypass;
		end else if (bypass) begin
			s_nxt.done = 1'b1;
		end else if (!s_r.done && osc_tick) begin
			s_nxt.cnt = s_r.cnt + 11'h001;
			if (s_nxt.cnt == START_UP_COUNT)
				s_nxt.done = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign done = s_r.done;
endmodule

// ==== system_clock_source_control.sv ====
// system clock source control: selects the main clock, multiplier and sleep behaviour
// assumes oscillator health levels and primary ticks are synchronous to CLK
// Overview of operation
// - four-bit config field fixes primary mode
// - some RC/EC/internal codes output quarter clock
// - select field picks primary, secondary, internal
// - select write switches source after transition
// - any reset selects primary clock
// - frequency code 111 16MHz, halving to 011
// - frequency write changes internal output immediately
// - reset restores 1 MHz frequency code
// - code 000 source chosen by two bits
// - watchdog and monitor always use low oscillator
// - lost external primary forces internal clock
// - multiplier engaged per mode and enable bits
// - idle bit chooses idle or full sleep
// - status shows multiplier drives system clock
// - drive enable powers primary circuit, resets set
// - status shows medium oscillator stable
// - status shows low oscillator stable
// - crystal modes wait 1024 primary cycles
module system_clock_source_control
	import clk_ctl_pkg::*;
(
	input wire logic CLK,
	input wire logic NRST,
	input wire reg_req_t REQ,
	output logic [7:0] RDATA,
	input wire cfg_t CFG,
	input wire osc_health_t HEALTH,
	input wire logic PRIMARY_TICK,
	input wire logic WAKE,
	input wire logic SLEEP_EXEC,
	output clk_src_t CLOCK_SOURCE,
	output int_tap_t INTERNAL_TAP,
	output logic MULTIPLIER_ON,
	output logic PRIMARY_DRIVE_ON,
	output logic SECONDARY_ON,
	output logic QUARTER_CLOCK_OUT,
	output logic SECOND_OSC_PIN_IO,
	output logic MONITOR_CLOCK_LOW,
	output logic CLOCK_FAILED,
	output logic SWITCHING,
	output logic EXEC_HOLD,
	output logic ENTER_IDLE,
	output logic ENTER_SLEEP
);
	typedef struct packed {
		logic [7:0] rdata;
		logic idle_on_sleep;
		logic [2:0] internal_freq_select;
		logic [1:0] system_clock_select;
		logic medium_osc_select;
		logic secondary_force_on;
		logic primary_drive_enable;
		logic fail_latched;
		logic [1:0] trans_cnt;
		clk_src_t src;
		int_tap_t tap;
		logic mult_on;
		logic quarter;
		logic [1:0] div4;
		logic pin_io;
		logic sec_on;
		logic hold;
		logic idle;
		logic sleep;
		logic switching;
		logic mon_low;
	} state_t;
	state_t s_r, s_nxt;

	logic restart_cnt;
	logic start_done;
	logic [3:0] mode;
	logic ext_primary;
	clk_src_t want_src;

	assign mode = CFG.primary_mode_config;
	assign ext_primary = !is_internal(mode);
	assign restart_cnt = WAKE;

	start_up_counter u_start (
		.clk(CLK),
		.nrst(NRST),
		.restart(restart_cnt),
		.bypass(!is_crystal(mode)),
		.osc_tick(PRIMARY_TICK),
		.done(start_done)
	);

	function automatic int_tap_t pick_tap(input logic [2:0] f, input logic med, input logic lsrc);
		int_tap_t t;
		t = INT_1M;
		case (f)
			3'h7: t = INT_16M;
			3'h6: t = INT_8M;
			3'h5: t = INT_4M;
			3'h4: t = INT_2M;
			3'h3: t = INT_1M;
			3'h2: t = med ? INT_500K_MF : INT_500K_HF;
			3'h1: t = med ? INT_250K_MF : INT_250K_HF;
			3'h0: begin
				if (!lsrc)
					t = INT_31K_LF;
				else
					t = med ? INT_31K_MF : INT_31K_HF;
			end
			default: t = INT_1M;
		endcase
		return t;
	endfunction

	always_comb begin
		s_nxt = s_r;
		s_nxt.rdata = 8'h00;
		s_nxt.idle = 1'b0;
		s_nxt.sleep = 1'b0;

		if (REQ.wr) begin
			case (REQ.addr)
				ADDR_SEL_CTL: begin
					s_nxt.idle_on_sleep = REQ.wdata[POS_IDLE];
					s_nxt.internal_freq_select = REQ.wdata[POS_FREQ +: 3];
					if (REQ.wdata[1:0] != s_r.system_clock_select)
						s_nxt.trans_cnt = TRANSITION_CYCLES;
					s_nxt.system_clock_select = REQ.wdata[1:0];
				end
				ADDR_STAT_AUX: begin
					s_nxt.medium_osc_select = REQ.wdata[POS_MEDSEL];
					s_nxt.secondary_force_on = REQ.wdata[POS_SECFORCE];
					s_nxt.primary_drive_enable = REQ.wdata[POS_DRIVE];
				end
				default: begin
				end
			endcase
		end

		if (REQ.rd) begin
			case (REQ.addr)
				ADDR_SEL_CTL: begin
					s_nxt.rdata[POS_IDLE] = s_r.idle_on_sleep;
					s_nxt.rdata[POS_FREQ +: 3] = s_r.internal_freq_select;
					s_nxt.rdata[POS_PRIRUN] = (s_r.src == SRC_PRIMARY);
					s_nxt.rdata[POS_HSTABLE] = HEALTH.high_ok;
					s_nxt.rdata[1:0] = s_r.system_clock_select;
				end
				ADDR_STAT_AUX: begin
					s_nxt.rdata[POS_MULTRUN] = s_r.mult_on;
					s_nxt.rdata[POS_SECRUN] = (s_r.src == SRC_SECONDARY);
					s_nxt.rdata[POS_MEDSEL] = s_r.medium_osc_select;
					s_nxt.rdata[POS_SECFORCE] = s_r.secondary_force_on;
					s_nxt.rdata[POS_DRIVE] = s_r.primary_drive_enable;
					s_nxt.rdata[POS_MSTABLE] = HEALTH.medium_ok;
					s_nxt.rdata[POS_LSTABLE] = HEALTH.low_ok;
				end
				default: s_nxt.rdata = 8'h00;
			endcase
		end

		// fail monitor, stays until a reset
		if (ext_primary && s_r.src == SRC_PRIMARY && s_r.hold == 1'b0 && !HEALTH.primary_ok)
			s_nxt.fail_latched = 1'b1;

		case (s_nxt.system_clock_select)
			2'h0: want_src = SRC_PRIMARY;
			2'h1: want_src = SRC_SECONDARY;
			default: want_src = SRC_INTERNAL;
		endcase
		if (s_nxt.fail_latched && want_src == SRC_PRIMARY)
			want_src = SRC_INTERNAL;

		// short transition before the new source takes over
		if (s_r.trans_cnt != 2'h0)
			s_nxt.trans_cnt = s_r.trans_cnt - 2'h1;
		if (s_nxt.trans_cnt == 2'h0)
			s_nxt.src = want_src;
		// registered so the port comes straight from a flip-flop
		s_nxt.switching = (s_nxt.trans_cnt != 2'h0);
		// watchdog and monitor stay on low oscillator
		s_nxt.mon_low = 1'b1;

		s_nxt.tap = pick_tap(s_nxt.internal_freq_select, s_nxt.medium_osc_select, CFG.low_freq_source_select);

		s_nxt.mult_on = 1'b0;
		if (s_nxt.src == SRC_PRIMARY && !s_nxt.fail_latched) begin
			if (mode <= MODE_RC_IO)
				s_nxt.mult_on = CFG.multiplier_config;
			else
				s_nxt.mult_on = CFG.multiplier_enable;
		end

		// second pin: io or quarter clock
		s_nxt.pin_io = (mode == MODE_RC_IO) || (mode == MODE_EC_HP_IO) || (mode == MODE_EC_MP_IO)
			|| (mode == MODE_INT_IO) || (mode >= 4'hC && mode[0]);
		s_nxt.div4 = s_r.div4 + 2'h1;
		s_nxt.quarter = !s_nxt.pin_io && s_nxt.div4[1];

		s_nxt.sec_on = s_nxt.secondary_force_on || (s_nxt.src == SRC_SECONDARY);
		s_nxt.hold = !start_done;

		if (SLEEP_EXEC) begin
			s_nxt.idle = s_r.idle_on_sleep;
			s_nxt.sleep = !s_r.idle_on_sleep;
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			s_r <= '0;
			s_r.system_clock_select <= SEL_RESET;
			s_r.internal_freq_select <= FREQ_RESET;
			s_r.tap <= INT_1M;
			s_r.primary_drive_enable <= DRIVE_RESET;
			s_r.medium_osc_select <= MEDSEL_RESET;
			s_r.idle_on_sleep <= IDLE_RESET;
			s_r.secondary_force_on <= SECFORCE_RESET;
			s_r.src <= SRC_PRIMARY;
			s_r.pin_io <= 1'b1;
			s_r.hold <= 1'b1;
			s_r.mon_low <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign RDATA = s_r.rdata;
	assign CLOCK_SOURCE = s_r.src;
	assign INTERNAL_TAP = s_r.tap;
	assign MULTIPLIER_ON = s_r.mult_on;
	assign PRIMARY_DRIVE_ON = s_r.primary_drive_enable;
	assign SECONDARY_ON = s_r.sec_on;
	assign QUARTER_CLOCK_OUT = s_r.quarter;
	assign SECOND_OSC_PIN_IO = s_r.pin_io;
	assign MONITOR_CLOCK_LOW = s_r.mon_low;
	assign CLOCK_FAILED = s_r.fail_latched;
	assign SWITCHING = s_r.switching;
	assign EXEC_HOLD = s_r.hold;
	assign ENTER_IDLE = s_r.idle;
	assign ENTER_SLEEP = s_r.sleep;
endmodule

// ==== clk_ctl_properties.sv ====
// checker for the clock source control block, watching only its top ports
// assumes one CLK domain and attachment by bind from the bench
module clk_ctl_checker
	import clk_ctl_pkg::*;
(
	input wire logic CLK,
	input wire logic NRST,
	input wire reg_req_t REQ,
	input wire cfg_t CFG,
	input wire logic SLEEP_EXEC,
	input wire clk_src_t CLOCK_SOURCE,
	input wire int_tap_t INTERNAL_TAP,
	input wire logic MULTIPLIER_ON,
	input wire logic PRIMARY_DRIVE_ON,
	input wire logic MONITOR_CLOCK_LOW,
	input wire logic ENTER_IDLE,
	input wire logic ENTER_SLEEP
);
	default clocking @(posedge CLK); endclocking
	// reset values are judged during reset, so these three carry no disable
	sel_reset_a: assert property (!NRST |=> CLOCK_SOURCE == SRC_PRIMARY) else $error("source not primary");
	freq_reset_a: assert property (!NRST |=> INTERNAL_TAP == INT_1M) else $error("tap not 1 MHz");
	drive_reset_a: assert property (!NRST |=> PRIMARY_DRIVE_ON) else $error("drive off after reset");
	mon_low_a: assert property (disable iff (!NRST) MONITOR_CLOCK_LOW) else $error("monitor clock moved");
	switch_a: assert property (disable iff (!NRST) (REQ.wr && !REQ.addr && REQ.wdata[1]) ##1 (!REQ.wr) [*2]
		|=> CLOCK_SOURCE == SRC_INTERNAL) else $error("switch to internal late");
	tap_a: assert property (disable iff (!NRST) REQ.wr && !REQ.addr && REQ.wdata[6:4] == 3'h7
		|=> INTERNAL_TAP == INT_16M) else $error("tap not 16 MHz");
	sleep_pick_a: assert property (disable iff (!NRST) SLEEP_EXEC |=> ENTER_IDLE ^ ENTER_SLEEP) else $error("no sleep pulse");
	sleep_quiet_a: assert property (disable iff (!NRST) !SLEEP_EXEC |=> !ENTER_IDLE && !ENTER_SLEEP)
		else $error("stray sleep pulse");
	mult_off_a: assert property (disable iff (!NRST)
		((CFG.primary_mode_config[3] ? CFG.multiplier_enable : CFG.multiplier_config) == 1'b0) [*2] |-> !MULTIPLIER_ON)
		else $error("multiplier on while disallowed");
	cover property (disable iff (!NRST) REQ.wr && !REQ.addr && REQ.wdata[1] ##3 CLOCK_SOURCE == SRC_INTERNAL);
	cover property (disable iff (!NRST) SLEEP_EXEC ##1 ENTER_IDLE);
	cover property (disable iff (!NRST) MULTIPLIER_ON);
endmodule

// ==== system_clock_source_control_bench.sv ====
// bench for the clock source control block: drives every port, judges the results
// assumes the checker module is compiled alongside; no partner model
module system_clock_source_control_bench
	import clk_ctl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK = 0, NRST = 0, PRIMARY_TICK = 0, WAKE = 0, SLEEP_EXEC = 0;
	reg_req_t REQ = '0;
	cfg_t CFG = '{MODE_EC_HP_IO, 1'b0, 1'b0, 1'b0, 1'b0};
	osc_health_t HEALTH = 5'h1F;
	logic [7:0] RDATA, rv;
	clk_src_t CLOCK_SOURCE;
	int_tap_t INTERNAL_TAP;
	logic MULTIPLIER_ON, PRIMARY_DRIVE_ON, SECOND_OSC_PIN_IO, CLOCK_FAILED, SWITCHING, EXEC_HOLD;
	logic ENTER_IDLE, ENTER_SLEEP, SECONDARY_ON, QUARTER_CLOCK_OUT;
	int err_count = 0, checks = 0, cyc = 0;
	system_clock_source_control dut (.CLK(CLK), .NRST(NRST), .REQ(REQ), .RDATA(RDATA), .CFG(CFG),
		.HEALTH(HEALTH), .PRIMARY_TICK(PRIMARY_TICK), .WAKE(WAKE), .SLEEP_EXEC(SLEEP_EXEC),
		.CLOCK_SOURCE(CLOCK_SOURCE), .INTERNAL_TAP(INTERNAL_TAP), .MULTIPLIER_ON(MULTIPLIER_ON),
		.PRIMARY_DRIVE_ON(PRIMARY_DRIVE_ON), .SECONDARY_ON(SECONDARY_ON), .QUARTER_CLOCK_OUT(QUARTER_CLOCK_OUT),
		.SECOND_OSC_PIN_IO(SECOND_OSC_PIN_IO), .MONITOR_CLOCK_LOW(), .CLOCK_FAILED(CLOCK_FAILED),
		.SWITCHING(SWITCHING), .EXEC_HOLD(EXEC_HOLD), .ENTER_IDLE(ENTER_IDLE), .ENTER_SLEEP(ENTER_SLEEP));
	always #50 CLK = ~CLK;
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// whole run needs about 2500 cycles
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			err_count++;
			tally_and_finish();
		end
	end
	task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cy(int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask
	task automatic wr(logic a, logic [7:0] d);
		@(posedge CLK);
		REQ <= '{a, d, 1'b1, 1'b0};
		@(posedge CLK);
		REQ.wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(logic a);
		@(posedge CLK);
		REQ <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge CLK);
		REQ.rd <= 1'b0;
		#1 rv = RDATA;
	endtask
	task automatic t_reset();
		cy(2);
		chk("source", 8'(CLOCK_SOURCE), 8'(SRC_PRIMARY));
		chk("tap", 8'(INTERNAL_TAP), 8'(INT_1M));
		chk("drive", 8'(PRIMARY_DRIVE_ON), 8'h01);
		rd(1'b0);
		chk("ctl", rv & 8'h7F, 8'h3C);
		rd(1'b1);
		chk("aux", rv & 8'h1C, 8'h04);
		for (int h = 0; h < 4; h++) begin
			HEALTH.medium_ok <= h[1];
			HEALTH.low_ok <= h[0];
			rd(1'b1);
			chk("stable", rv & 8'h03, 8'(h));
		end
	endtask
	task automatic t_switch();
		logic [1:0] ss[4] = '{2'h1, 2'h3, 2'h0, 2'h2};
		clk_src_t es[4] = '{SRC_SECONDARY, SRC_INTERNAL, SRC_PRIMARY, SRC_INTERNAL};
		for (int i = 0; i < 4; i++) begin
			wr(1'b0, {1'b0, 3'h3, 2'h0, ss[i]});
			#1;
			chk("switching", 8'(SWITCHING), 8'h01);
			cy(2);
			chk("source", 8'(CLOCK_SOURCE), 8'(es[i]));
			chk("secon", 8'(SECONDARY_ON), 8'(es[i] == SRC_SECONDARY));
		end
	endtask
	task automatic t_freq();
		int_tap_t e;
		for (int m = 0; m < 2; m++) for (int l = 0; l < 2; l++) begin
			CFG.low_freq_source_select <= l[0];
			wr(1'b1, {3'h0, m[0], 4'h4});
			for (int c = 0; c < 8; c++) begin
				e = c >= 3 ? int_tap_t'(4'(7 - c)) : c == 2 ? (m ? INT_500K_MF : INT_500K_HF) :
					c == 1 ? (m ? INT_250K_MF : INT_250K_HF) : !l ? INT_31K_LF : m ? INT_31K_MF : INT_31K_HF;
				wr(1'b0, {1'b0, 3'(c), 2'h0, 2'h2});
				#1;
				chk("tap", 8'(INTERNAL_TAP), 8'(e));
			end
		end
	endtask
	task automatic t_sleep();
		for (int i = 0; i < 2; i++) begin
			wr(1'b0, {i[0], 3'h3, 2'h0, 2'h0});
			@(posedge CLK);
			SLEEP_EXEC <= 1'b1;
			@(posedge CLK);
			SLEEP_EXEC <= 1'b0;
			#1;
			chk("idle", 8'(ENTER_IDLE), 8'(i[0]));
			chk("sleep", 8'(ENTER_SLEEP), 8'(!i[0]));
		end
	endtask
	task automatic t_mult();
		logic e;
		logic [7:0] q;
		for (int md = 0; md < 16; md++) for (int k = 0; k < 4; k++) begin
			CFG.primary_mode_config <= 4'(md);
			CFG.multiplier_config <= k[0];
			CFG.multiplier_enable <= k[1];
			e = md > 7 ? k[1] : k[0];
			cy(3);
			chk("mult", 8'(MULTIPLIER_ON), 8'(e));
			rd(1'b1);
			chk("multrun", 8'(rv[7]), 8'(e));
			if (md inside {[4:9]}) chk("pin", 8'(SECOND_OSC_PIN_IO), 8'(md inside {5, 7, 8}));
			if (md == 9 && k == 0) begin
				q = 8'h00;
				repeat (4) begin
					@(posedge CLK);
					#1 q = q + 8'(QUARTER_CLOCK_OUT);
				end
				chk("quarter", q, 8'h02);
			end
		end
	endtask
	task automatic t_startup();
		CFG <= '{MODE_XT, 1'b0, 1'b0, 1'b0, 1'b0};
		@(posedge CLK);
		WAKE <= 1'b1;
		@(posedge CLK);
		WAKE <= 1'b0;
		for (int t = 0; t < 1024; t++) begin
			if (t == 1023) chk("hold", 8'(EXEC_HOLD), 8'h01);
			@(posedge CLK);
			PRIMARY_TICK <= 1'b1;
			@(posedge CLK);
			PRIMARY_TICK <= 1'b0;
		end
		cy(4);
		chk("release", 8'(EXEC_HOLD), 8'h00);
	endtask
	task automatic t_fail();
		CFG.primary_mode_config <= MODE_EC_HP_IO;
		HEALTH.primary_ok <= 1'b0;
		cy(6);
		chk("failed", 8'(CLOCK_FAILED), 8'h01);
		chk("source", 8'(CLOCK_SOURCE), 8'(SRC_INTERNAL));
		HEALTH.primary_ok <= 1'b1;
		NRST <= 1'b0;
		cy(2);
		NRST <= 1'b1;
		cy(2);
		chk("failed", 8'(CLOCK_FAILED), 8'h00);
		chk("source", 8'(CLOCK_SOURCE), 8'(SRC_PRIMARY));
	endtask
	initial begin
		repeat (4) @(posedge CLK);
		NRST <= 1'b1;
		t_reset();
		t_switch();
		t_freq();
		t_sleep();
		t_mult();
		t_startup();
		t_fail();
		tally_and_finish();
	end
endmodule
bind system_clock_source_control clk_ctl_checker chk_i (.CLK(CLK), .NRST(NRST), .REQ(REQ), .CFG(CFG),
	.SLEEP_EXEC(SLEEP_EXEC), .CLOCK_SOURCE(CLOCK_SOURCE), .INTERNAL_TAP(INTERNAL_TAP),
	.MULTIPLIER_ON(MULTIPLIER_ON), .PRIMARY_DRIVE_ON(PRIMARY_DRIVE_ON), .MONITOR_CLOCK_LOW(MONITOR_CLOCK_LOW),
	.ENTER_IDLE(ENTER_IDLE), .ENTER_SLEEP(ENTER_SLEEP));
